// ---- logic/fsc_forced_stop.sv ----
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
module fsc_forced_stop
    import fsc_pkg::*;
#(
    parameter int          NUM_INPUTS  = 8,
    parameter logic [31:0] MAX_SPEED   = 32'h0000_FFFF,
    parameter int          CYC_PER_MS  = FSC_CYC_PER_MS
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [15:0]           adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    output logic                       err_o,
    // external pins and drive state
    input  wire logic [NUM_INPUTS-1:0] in_pins_i,
    input  wire logic                  servo_on_i,
    input  wire logic                  torque_ctrl_i,
    input  wire logic [31:0]           speed_fb_i,
    // drive command and interrupt
    output fsc_drive_s                 drive_o,
    output logic                       irq_o
);

    localparam int SEL_W = $clog2(NUM_INPUTS);

    // registers
    logic [15:0]          method_reg_q;
    logic [15:0]          decel_q;
    logic [15:0]          estop_trq_q;
    logic [15:0]          ctrl_q;
    logic [15:0]          maxtrq_q;
    logic [FSC_IRQ_W-1:0] irq_stat_q;
    logic [FSC_IRQ_W-1:0] irq_mask_q;
    fsc_method_e          method_q;
    logic                 ack_q;
    logic                 err_q;
    logic [31:0]          rdat_q;

    // input sync and stop tracking
    logic [NUM_INPUTS-1:0] s1_q;
    logic [NUM_INPUTS-1:0] s2_q;
    logic [NUM_INPUTS-1:0] s3_q;
    logic [NUM_INPUTS-1:0] stable_q;
    fsc_state_e            state_q;
    logic                  latch_q;
    logic                  servo_on_q;
    logic [31:0]           speed_q;
    logic [31:0]           step_q;
    logic [31:0]           div_num_q;
    logic [31:0]           div_cnt_q;
    logic                  div_busy_q;
    logic [31:0]           rem_q;
    logic [15:0]           dvs_q;

    // decode helpers, used by bus read and write paths
    function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_adr);
        hit = (a == reg_adr);
    endfunction

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
        clamp16 = (v > lim) ? lim : v;
    endfunction

    wire        req       = cyc_i && stb_i && !ack_q && !err_q;
    // offsets are indices; byte address is index times four
    wire [15:0] idx       = adr_i >> FSC_IDX_SHIFT;
    wire        mapped    = hit(idx, FSC_ADDR_METHOD) || hit(idx, FSC_ADDR_DECEL) ||
                            hit(idx, FSC_ADDR_ESTOP_TRQ) || hit(idx, FSC_ADDR_CTRL) ||
                            hit(idx, FSC_ADDR_STATUS) || hit(idx, FSC_ADDR_IRQ_STAT) ||
                            hit(idx, FSC_ADDR_IRQ_MASK) || hit(idx, FSC_ADDR_MAXTRQ);
    wire        wr        = req && we_i && mapped && (adr_i[1:0] == 2'h0);
    wire [15:0] wdat      = {sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};
    wire        wlo       = sel_i[0];
    wire        whi       = sel_i[1];

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic lo, input logic hi);
        merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
    endfunction

    // bus answer: one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && mapped && (adr_i[1:0] == 2'h0);
            err_q <= req && !(mapped && (adr_i[1:0] == 2'h0));
        end
    end

    // parameter registers; decel time and stop torque above range are clamped on write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            method_reg_q <= FSC_METHOD_RST;
            decel_q      <= FSC_DECEL_RST;
            estop_trq_q  <= FSC_ESTOP_TRQ_RST;
            ctrl_q       <= 16'h0000;
            maxtrq_q     <= FSC_MAXTRQ_RST;
            irq_mask_q   <= '0;
        end else begin
            if (wr && hit(idx, FSC_ADDR_METHOD)) begin
                method_reg_q <= merge(method_reg_q, wdat, wlo, whi);
            end
            if (wr && hit(idx, FSC_ADDR_DECEL)) begin
                decel_q <= clamp16(merge(decel_q, wdat, wlo, whi), FSC_DECEL_MAX);
            end
            if (wr && hit(idx, FSC_ADDR_ESTOP_TRQ)) begin
                estop_trq_q <= clamp16(merge(estop_trq_q, wdat, wlo, whi), FSC_ESTOP_TRQ_MAX);
            end
            if (wr && hit(idx, FSC_ADDR_CTRL)) begin
                ctrl_q <= merge(ctrl_q, wdat, wlo, whi) & 16'h7FFF;
            end
            if (wr && hit(idx, FSC_ADDR_MAXTRQ)) begin
                maxtrq_q <= merge(maxtrq_q, wdat, wlo, whi);
            end
            if (wr && hit(idx, FSC_ADDR_IRQ_MASK) && wlo) begin
                irq_mask_q <= dat_i[FSC_IRQ_W-1:0];
            end
        end
    end

    // method captured at reset and at a software restart only
    wire restart_wr = wr && hit(idx, FSC_ADDR_CTRL) && whi && dat_i[FSC_CTRL_RESTART];
    wire [3:0] method_fld = method_reg_q[FSC_METHOD_LSB +: 4];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            method_q <= FSC_M_TRQ_HOLD;
        end else if (restart_wr) begin
            method_q <= (method_fld > 4'h4) ? FSC_M_TRQ_HOLD : fsc_method_e'(method_fld[2:0]);
        end
    end

    // three-stage sync; change accepted when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q     <= '1;
            s2_q     <= '1;
            s3_q     <= '1;
            stable_q <= '1;
        end else begin
            s1_q <= in_pins_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NUM_INPUTS; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stable_q[i] <= s3_q[i];
                end
            end
        end
    end

    // allocation select
    wire [1:0] alloc_mode  = ctrl_q[FSC_CTRL_ALLOC_LSB +: 2];
    wire [3:0] single_sel  = ctrl_q[FSC_CTRL_SINGLE_LSB +: 4];
    wire [3:0] multi_sel   = ctrl_q[FSC_CTRL_MULTI_LSB +: 4];
    wire [3:0] pin_sel     = (alloc_mode == 2'h2) ? multi_sel : single_sel;
    wire       allocated   = ((alloc_mode == 2'h1) || (alloc_mode == 2'h2)) &&
                             (pin_sel < 4'(NUM_INPUTS));
    // unallocated input counts as closed so the drive runs
    wire       input_closed = !allocated || stable_q[pin_sel[SEL_W-1:0]];
    wire       stop_req     = !input_closed || latch_q;
    wire       soff_db      = ctrl_q[FSC_CTRL_SOFF_DB];

    // latch: set by open input under servo on, cleared by servo off with the input closed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q    <= 1'b0;
            servo_on_q <= 1'b0;
        end else begin
            servo_on_q <= servo_on_i;
            if (!input_closed && servo_on_i) begin
                latch_q <= 1'b1;
            end else if (!servo_on_i && input_closed) begin
                latch_q <= 1'b0;
            end
        end
    end

    // effective torque limit
    wire [15:0] trq_lim = (estop_trq_q > maxtrq_q) ? maxtrq_q : estop_trq_q;

    // step per ms = max speed / decel time, one quotient bit per cycle
    // a fixed round of 34 cycles keeps a new decel time live well inside one ms
    wire [32:0] rem_sh  = {rem_q, div_num_q[31]};
    wire [32:0] rem_sub = rem_sh - {17'h00000, dvs_q};
    wire        rem_ge  = (rem_sh >= {17'h00000, dvs_q});

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_num_q  <= '0;
            div_cnt_q  <= '0;
            div_busy_q <= 1'b0;
            rem_q      <= '0;
            dvs_q      <= '0;
            step_q     <= MAX_SPEED;
        end else if (!div_busy_q) begin
            div_num_q  <= MAX_SPEED;
            div_cnt_q  <= '0;
            rem_q      <= '0;
            dvs_q      <= decel_q;
            div_busy_q <= (decel_q != 16'h0000);
            if (decel_q == 16'h0000) begin
                step_q <= MAX_SPEED;
            end
        end else if (div_cnt_q != 32'h0000_0020) begin
            rem_q     <= rem_ge ? rem_sub[31:0] : rem_sh[31:0];
            div_num_q <= {div_num_q[30:0], rem_ge};
            div_cnt_q <= div_cnt_q + 32'h1;
        end else begin
            // remainder rounds up so ramp never exceeds the set time
            step_q     <= div_num_q + ((rem_q != 32'h0) ? 32'h1 : 32'h0);
            div_busy_q <= 1'b0;
        end
    end

    // 1 ms tick for the timed ramp
    logic [31:0] ms_cnt_q;
    wire         ms_tick = (ms_cnt_q == 32'(CYC_PER_MS - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || ms_tick || state_q != FSC_S_DEC_TIME) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h1;
        end
    end

    wire        stopped  = (speed_q == 32'h0);
    // zero time holds the zero-speed command until the motor is really at rest
    wire        time_done = (decel_q == 16'h0000) ? (speed_fb_i == 32'h0) : stopped;
    wire        db_after = soff_db;
    fsc_state_e brake_st;
    assign brake_st = db_after ? FSC_S_BRAKE : FSC_S_COAST;

    // stop sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= FSC_S_RUN;
            speed_q <= '0;
        end else begin
            case (state_q)
                FSC_S_RUN: begin
                    speed_q <= speed_fb_i;
                    if (stop_req) begin
                        if (torque_ctrl_i) begin
                            state_q <= brake_st;
                        end else begin
                            case (method_q)
                                FSC_M_DB_COAST:  state_q <= brake_st;
                                FSC_M_TRQ_HOLD,
                                FSC_M_TRQ_COAST: state_q <= FSC_S_DEC_TRQ;
                                default:         state_q <= FSC_S_DEC_TIME;
                            endcase
                        end
                    end
                end
                FSC_S_DEC_TRQ: begin
                    speed_q <= speed_fb_i;
                    if (torque_ctrl_i) begin
                        state_q <= brake_st;
                    end else if (speed_fb_i == 32'h0) begin
                        state_q <= (method_q == FSC_M_TRQ_COAST) ? FSC_S_COAST : brake_st;
                    end
                end
                FSC_S_DEC_TIME: begin
                    if (decel_q == 16'h0000) begin
                        speed_q <= '0;
                    end else if (ms_tick) begin
                        speed_q <= (speed_q > step_q) ? speed_q - step_q : 32'h0;
                    end
                    if (torque_ctrl_i) begin
                        state_q <= brake_st;
                    end else if (time_done) begin
                        state_q <= (method_q == FSC_M_TIME_COAST) ? FSC_S_COAST : brake_st;
                    end
                end
                FSC_S_BRAKE,
                FSC_S_COAST: begin
                    speed_q <= '0;
                    if (!stop_req) begin
                        state_q <= FSC_S_RUN;
                    end
                end
                default: state_q <= FSC_S_RUN;
            endcase
        end
    end

    // sticky interrupt status, write one to clear, set wins
    logic [FSC_IRQ_W-1:0] ev;
    assign ev[FSC_IRQ_ENTER]   = (state_q == FSC_S_RUN) && stop_req;
    assign ev[FSC_IRQ_STOPPED] = (state_q == FSC_S_DEC_TRQ || state_q == FSC_S_DEC_TIME) &&
                                 (state_q == FSC_S_DEC_TRQ ? speed_fb_i == 32'h0 : time_done);
    assign ev[FSC_IRQ_CLEARED] = (state_q == FSC_S_BRAKE || state_q == FSC_S_COAST) && !stop_req;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr && hit(idx, FSC_ADDR_IRQ_STAT) && wlo) ?
                           dat_i[FSC_IRQ_W-1:0] : '0)) | ev;
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // read data registered with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (req) begin
            case (idx)
                FSC_ADDR_METHOD:    rdat_q <= {16'h0000, method_reg_q};
                FSC_ADDR_DECEL:     rdat_q <= {16'h0000, decel_q};
                FSC_ADDR_ESTOP_TRQ: rdat_q <= {16'h0000, estop_trq_q};
                FSC_ADDR_CTRL:      rdat_q <= {16'h0000, ctrl_q};
                FSC_ADDR_STATUS:    rdat_q <= {24'h000000, latch_q, state_q, input_closed,
                                               allocated, servo_on_q, state_q != FSC_S_RUN};
                FSC_ADDR_IRQ_STAT:  rdat_q <= {29'h0, irq_stat_q};
                FSC_ADDR_IRQ_MASK:  rdat_q <= {29'h0, irq_mask_q};
                FSC_ADDR_MAXTRQ:    rdat_q <= {16'h0000, maxtrq_q};
                default:            rdat_q <= '0;
            endcase
        end
    end

    assign dat_o = rdat_q;
    assign ack_o = ack_q;
    assign err_o = err_q;

    // zero-speed stop: reference forced to zero in the same cycle as the command
    wire        zero_cmd = (state_q == FSC_S_DEC_TIME) && (decel_q == 16'h0000);

    // drive command outputs from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_o <= '0;
        end else begin
            drive_o.stop_active  <= (state_q != FSC_S_RUN);
            drive_o.decel        <= (state_q == FSC_S_DEC_TRQ) || (state_q == FSC_S_DEC_TIME);
            drive_o.dyn_brake    <= (state_q == FSC_S_BRAKE);
            drive_o.coast        <= (state_q == FSC_S_COAST);
            drive_o.zero_speed   <= zero_cmd;
            drive_o.torque_limit <= (state_q == FSC_S_DEC_TRQ) ? trq_lim : maxtrq_q;
            drive_o.speed_ref    <= ((state_q == FSC_S_RUN) || zero_cmd) ? 32'h0 : speed_q;
        end
    end

endmodule

// ---- logic/fsc_pkg.sv ----
package fsc_pkg;

    // register indices; the byte address on the bus is the index times four
    localparam logic [15:0] FSC_ADDR_METHOD    = 16'h200A;
    localparam logic [15:0] FSC_ADDR_DECEL     = 16'h230A;
    localparam logic [15:0] FSC_ADDR_ESTOP_TRQ = 16'h2406;
    // own registers
    localparam logic [15:0] FSC_ADDR_CTRL      = 16'h3000;
    localparam logic [15:0] FSC_ADDR_STATUS    = 16'h3004;
    localparam logic [15:0] FSC_ADDR_IRQ_STAT  = 16'h3008;
    localparam logic [15:0] FSC_ADDR_IRQ_MASK  = 16'h300C;
    localparam logic [15:0] FSC_ADDR_MAXTRQ    = 16'h3010;

    // register offsets are not word aligned, so they are treated as indices
    localparam int          FSC_IDX_SHIFT      = 2;

    // reset values and write limits
    localparam logic [15:0] FSC_METHOD_RST     = 16'h0010;
    localparam logic [15:0] FSC_DECEL_RST      = 16'h0000;
    localparam logic [15:0] FSC_ESTOP_TRQ_RST  = 16'h0320;
    localparam logic [15:0] FSC_ESTOP_TRQ_MAX  = 16'h0320;
    localparam logic [15:0] FSC_DECEL_MAX      = 16'h2710;
    localparam logic [15:0] FSC_MAXTRQ_RST     = 16'h012C;

    // field positions
    localparam int          FSC_METHOD_LSB     = 4;
    localparam int          FSC_CTRL_SOFF_DB   = 0;
    localparam int          FSC_CTRL_ALLOC_LSB = 1;
    localparam int          FSC_CTRL_SINGLE_LSB = 4;
    localparam int          FSC_CTRL_MULTI_LSB  = 8;
    localparam int          FSC_CTRL_RESTART   = 15;

    // interrupt bits
    localparam int          FSC_IRQ_ENTER      = 0;
    localparam int          FSC_IRQ_STOPPED    = 1;
    localparam int          FSC_IRQ_CLEARED    = 2;
    localparam int          FSC_IRQ_W          = 3;

    // timing
    localparam int          FSC_CLK_HZ         = 50_000_000;
    localparam int          FSC_MS_UNIT        = 1;
    localparam int          FSC_CYC_PER_MS     = FSC_CLK_HZ / 1000 * FSC_MS_UNIT;

    typedef enum logic [2:0] {
        FSC_M_DB_COAST   = 3'h0,
        FSC_M_TRQ_HOLD   = 3'h1,
        FSC_M_TRQ_COAST  = 3'h2,
        FSC_M_TIME_HOLD  = 3'h3,
        FSC_M_TIME_COAST = 3'h4
    } fsc_method_e;

    typedef enum logic [2:0] {
        FSC_S_RUN      = 3'h0,
        FSC_S_DEC_TRQ  = 3'h1,
        FSC_S_DEC_TIME = 3'h2,
        FSC_S_BRAKE    = 3'h3,
        FSC_S_COAST    = 3'h4
    } fsc_state_e;

    // drive command bundle presented to the power stage
    typedef struct packed {
        logic        stop_active;
        logic        decel;
        logic        dyn_brake;
        logic        coast;
        logic        zero_speed;
        logic [15:0] torque_limit;
        logic [31:0] speed_ref;
    } fsc_drive_s;

endpackage

// ---- verif/fsc_forced_stop_sva.sv ----
`timescale 1ns/1ns
module fsc_forced_stop_sva
    import fsc_pkg::*;
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // bus
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       err_o,
    // drive
    input wire logic       servo_on_i,
    input wire logic       torque_ctrl_i,
    input wire fsc_drive_s drive_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // cycles since servo on last returned after the host withdrew it
    logic [3:0] off_age_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !servo_on_i) begin
            off_age_q <= 4'h0;
        end else if (off_age_q != 4'hF) begin
            off_age_q <= off_age_q + 4'h1;
        end
    end

    sequence req_s;
        $rose(cyc_i && stb_i);
    endsequence
    sequence ans_s;
        (ack_o ^ err_o) ##1 !(ack_o || err_o);
    endsequence

    bus_answer_a: assert property (req_s |=> ans_s)
        else $error("request not answered by a single pulse");
    no_stray_a: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
        else $error("answer without a request");
    trq_cap_a: assert property (drive_o.torque_limit <= FSC_ESTOP_TRQ_MAX)
        else $error("torque limit above range");
    decel_stop_a: assert property (drive_o.decel |-> drive_o.stop_active)
        else $error("decel outside a forced stop");
    trq_mode_a: assert property (torque_ctrl_i [*3] ##0 drive_o.stop_active |-> !drive_o.decel)
        else $error("decel during torque control");
    brake_excl_a: assert property (!(drive_o.dyn_brake && drive_o.coast))
        else $error("brake and coast together");
    zero_ref_a: assert property (drive_o.zero_speed |-> drive_o.speed_ref == 32'h0)
        else $error("zero speed with nonzero reference");
    latch_hold_a: assert property ($fell(drive_o.stop_active) |-> off_age_q < 4'hC)
        else $error("stop released without servo off");
endmodule

bind fsc_forced_stop fsc_forced_stop_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .err_o(err_o), .servo_on_i(servo_on_i), .torque_ctrl_i(torque_ctrl_i), .drive_o(drive_o));

// ---- verif/fsc_host_model.sv ----
`timescale 1ns/1ns
module fsc_host_model #(
    parameter int OFF_CYC = 4
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // request an off/on cycle
    input  wire logic cycle_req_i,
    output logic      servo_on_o
);
    logic [7:0] cnt_q;
    // servo off is held for OFF_CYC plus one cycles before servo on returns
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            servo_on_o <= 1'b0;
            cnt_q      <= 8'h00;
        end else if (cycle_req_i) begin
            servo_on_o <= 1'b0;
            cnt_q      <= 8'(OFF_CYC);
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            servo_on_o <= 1'b1;
        end
    end
endmodule

// ---- verif/fsc_forced_stop_test.sv ----
`timescale 1ns/1ns
module fsc_forced_stop_test
    import fsc_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        trq_i = 1'b0, host_req = 1'b0, ack_o, err_o, irq_o, servo_on, er;
    logic [15:0] adr_i = 16'h0000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, spd_i = 32'h0, dat_o, rd;
    logic [7:0]  pins_i = 8'hFF;
    fsc_drive_s  drv;
    int          failures = 0, checks_done = 0;

    always #10 clk_i = ~clk_i;

    fsc_forced_stop #(.CYC_PER_MS(10)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .err_o, .in_pins_i(pins_i), .servo_on_i(servo_on), .torque_ctrl_i(trq_i),
        .speed_fb_i(spd_i), .drive_o(drv), .irq_o);
    fsc_host_model host (.clk_i, .rst_i, .cycle_req_i(host_req), .servo_on_o(servo_on));

    task automatic end_sim;
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; ack is sampled at the edge, then released
    task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'hF;
        adr_i <= {idx[13:0], 2'b00};
        dat_i <= {16'h0000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        rd = dat_o;
        er = err_o;
        if (n >= 20) chk("bus answer", 1, 0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 16'h0000);
        chk(nm, e, rd);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // close the input, then the host cycles servo off and on
    task automatic release_stop;
        pins_i <= 8'hFF;
        idle(8);
        host_req <= 1'b1;
        idle(1);
        host_req <= 1'b0;
        idle(16);
        chk("stop after release", 0, drv.stop_active);
    endtask

    task automatic t_regs;
        rdc("method reset", FSC_ADDR_METHOD, 32'h10);
        rdc("decel reset", FSC_ADDR_DECEL, 32'h0);
        rdc("torque reset", FSC_ADDR_ESTOP_TRQ, 32'h320);
        wb(1'b1, FSC_ADDR_ESTOP_TRQ, 16'h03FF);
        rdc("torque clamp", FSC_ADDR_ESTOP_TRQ, 32'h320);
        wb(1'b1, FSC_ADDR_DECEL, 16'hFFFF);
        rdc("decel clamp", FSC_ADDR_DECEL, 32'h2710);
        wb(1'b0, 16'h0001, 16'h0000);
        chk("unmapped err", 1, er);
    endtask

    task automatic t_alloc;
        wb(1'b1, FSC_ADDR_CTRL, 16'h0000);
        wb(1'b1, FSC_ADDR_IRQ_MASK, 16'h0001);
        pins_i <= 8'h00;
        idle(10);
        chk("unallocated stop", 0, drv.stop_active);
        pins_i <= 8'hFF;
        // let the closed level pass the synchroniser before the pin is allocated
        idle(6);
        wb(1'b1, FSC_ADDR_CTRL, 16'h0023);
        wb(1'b1, FSC_ADDR_METHOD, 16'h0000);
        spd_i <= 32'd100;
        idle(10);
        chk("run stop", 0, drv.stop_active);
        pins_i <= 8'hFB;
        idle(10);
        chk("stop active", 1, drv.stop_active);
        chk("method kept", 1, drv.decel);
        chk("torque motor max", 16'h012C, drv.torque_limit);
        chk("irq enter", 1, irq_o);
        rdc("status stop", FSC_ADDR_STATUS, 32'h97);
        wb(1'b1, FSC_ADDR_ESTOP_TRQ, 16'h0064);
        idle(4);
        chk("torque live", 16'h0064, drv.torque_limit);
        wb(1'b1, FSC_ADDR_ESTOP_TRQ, 16'h0320);
        wb(1'b1, FSC_ADDR_IRQ_MASK, 16'h0000);
        chk("irq masked", 0, irq_o);
        wb(1'b1, FSC_ADDR_IRQ_STAT, 16'h0007);
        wb(1'b1, FSC_ADDR_IRQ_MASK, 16'h0007);
        chk("irq cleared", 0, irq_o);
        pins_i <= 8'hFF;
        idle(10);
        chk("latched", 1, drv.stop_active);
        spd_i <= 32'd0;
        release_stop();
        chk("irq release", 1, irq_o);
        wb(1'b1, FSC_ADDR_IRQ_STAT, 16'h0007);
        chk("irq w1c", 0, irq_o);
        wb(1'b1, FSC_ADDR_CTRL, 16'h0505);
        pins_i <= 8'hFB;
        idle(10);
        chk("other pin", 0, drv.stop_active);
        pins_i <= 8'hDF;
        idle(10);
        chk("multi pin", 1, drv.stop_active);
        release_stop();
    endtask

    task automatic t_methods;
        for (int m = 0; m < 5; m++) begin
            wb(1'b1, FSC_ADDR_DECEL, (m == 3) ? 16'h0002 : 16'h0000);
            wb(1'b1, FSC_ADDR_METHOD, 16'(m << FSC_METHOD_LSB));
            wb(1'b1, FSC_ADDR_CTRL, 16'h8023);
            spd_i <= 32'h0000FFFF;
            pins_i <= 8'hFB;
            idle(10);
            if (m < 3) chk("decel", 32'(m != 0), drv.decel);
            if (m == 0) chk("method0 brake", 1, drv.dyn_brake);
            if (m == 3) chk("ramp running", 1, drv.speed_ref != 32'h0);
            if (m == 4) chk("zero speed", 1, drv.zero_speed);
            spd_i <= 32'h0;
            idle(40);
            if (m == 3) chk("ramp end", 0, drv.speed_ref);
            chk("coast after", 32'(m == 2 || m == 4), drv.coast);
            chk("brake after", 32'(m != 2 && m != 4), drv.dyn_brake);
            release_stop();
        end
    endtask

    task automatic t_trq;
        wb(1'b1, FSC_ADDR_METHOD, 16'h0010);
        wb(1'b1, FSC_ADDR_CTRL, 16'h8023);
        trq_i <= 1'b1;
        spd_i <= 32'd100;
        idle(4);
        pins_i <= 8'hFB;
        idle(10);
        chk("torque decel", 0, drv.decel);
        chk("torque brake", 1, drv.dyn_brake);
        spd_i <= 32'd0;
        release_stop();
        trq_i <= 1'b0;
    endtask

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_alloc();
        t_methods();
        t_trq();
        end_sim();
    end
endmodule
